/* File: src/dce_pkg.sv */
package dce_pkg;

  // ----------------------------------------
  // Operation codes
  // ----------------------------------------
  typedef enum logic [4:0] {
    DCE_OP_NONE     = 5'h00,
    DCE_OP_DIV_S    = 5'h01,
    DCE_OP_SIGNED_WIDE_QUOTIENT_OP   = 5'h02,
    DCE_OP_DIV_U    = 5'h03,
    DCE_OP_UNSIGNED_WIDE_QUOTIENT_OP   = 5'h04,
    DCE_OP_FRACTIONAL_QUOTIENT_OP     = 5'h05,
    DCE_OP_LOOP_LIT = 5'h06,
    DCE_OP_LOOP_REG = 5'h07,
    DCE_OP_DIST_SQ  = 5'h08,
    DCE_OP_SIGN_SCN = 5'h09,
    DCE_OP_LEAD_SCN = 5'h0A,
    DCE_OP_TRAIL_SC = 5'h0B,
    DCE_OP_LSR1     = 5'h0C,
    DCE_OP_LSRN     = 5'h0D,
    DCE_OP_LIT16    = 5'h0E,
    DCE_OP_LIT8     = 5'h0F,
    DCE_OP_DBL_FROM = 5'h10,
    DCE_OP_DBL_TO   = 5'h11,
    DCE_OP_PREFETCH = 5'h12
  } dce_op_t;

  // ----------------------------------------
  // Timing and reset values
  // ----------------------------------------
  localparam logic [4:0] DCE_DIV_CYCLES = 5'h12;   // 18 instruction cycles
  localparam logic [4:0] DCE_LOOP_CYCLES = 5'h02;
  localparam logic [4:0] DCE_DBL_CYCLES = 5'h02;
  localparam logic [15:0] DCE_WORD_RST = 16'h0000;
  localparam int DCE_LIT14_W = 14;

  // Issued instruction
  typedef struct packed {
    dce_op_t op;
    logic [15:0] src_a;     // Dividend low / source / literal / count
    logic [15:0] src_b;     // Divisor / dividend high / shift amount / pair high
    logic [15:0] src_c;     // Loop offset / X prefetch / wide divisor
    logic [15:0] src_d;     // Y prefetch (accumulator write-back value comes from src_a)
    logic awb_en;           // Accumulator write-back requested
  } dce_instr_t;

  // Status flags
  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic ov;
    logic acc_a_overflow_flag;
    logic acc_b_overflow_flag;
    logic either_acc_overflow_flag;
    logic acc_a_clipped_flag;
    logic acc_b_clipped_flag;
    logic any_acc_clipped_flag;
  } dce_flags_t;

  localparam dce_flags_t DCE_FLAGS_RST = '0;

  // Results
  typedef struct packed {
    logic [15:0] lo;        // Quotient / result / low word
    logic [15:0] hi;        // Remainder / high word / Y prefetch
    logic [39:0] acc;       // Accumulator result
  } dce_result_t;

endpackage

/* File: src/dce_divider.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Iterative restoring divider, one bit per cycle
// ----------------------------------------
module dce_divider
  import dce_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic is_signed_i,
  input wire logic is_wide_i,
  input wire logic is_frac_i,
  input wire logic [15:0] dvd_lo_i,
  input wire logic [15:0] dvd_hi_i,
  input wire logic [15:0] dvs_i,
  output logic [15:0] quot_o,
  output logic [15:0] rem_o,
  output logic ovf_o
);

  logic [31:0] mag_dvd;
  logic [15:0] mag_dvs;
  logic [31:0] shreg;
  logic [16:0] rem;
  logic [15:0] dvs;
  logic neg_q;
  logic neg_r;
  logic ovf;
  logic [16:0] trial;

  // Operand magnitudes and divide setup
  always_comb begin
    logic [31:0] dvd;
    dvd = 32'h0000_0000;
    if (is_frac_i) begin
      dvd = {1'b0, dvd_lo_i, 15'h0000};
    end else if (is_wide_i) begin
      dvd = {dvd_hi_i, dvd_lo_i};
    end else if (is_signed_i) begin
      dvd = {{16{dvd_lo_i[15]}}, dvd_lo_i};
    end else begin
      dvd = {16'h0000, dvd_lo_i};
    end
    mag_dvd = (is_signed_i && dvd[31] && !is_frac_i) ? 32'(-dvd) : dvd;
    if (is_frac_i && dvd_lo_i[15]) begin
      mag_dvd = {1'b0, 16'(-dvd_lo_i), 15'h0000};
    end
    mag_dvs = (is_signed_i && dvs_i[15]) ? 16'(-dvs_i) : dvs_i;
  end

  assign trial = {rem[15:0], shreg[31]} - {1'b0, dvs};

  // Shift-subtract iteration
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shreg <= 32'h0000_0000;
      rem <= 17'h0_0000;
      dvs <= 16'h0000;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      ovf <= 1'b0;
    end else if (start_i) begin
      // High half seeds the remainder, low half is shifted in over 16 steps
      shreg <= {mag_dvd[15:0], 16'h0000};
      rem <= {1'b0, mag_dvd[31:16]};
      dvs <= mag_dvs;
      neg_q <= is_signed_i & (dvd_hi_i[15] ^ dvs_i[15]) & is_wide_i
             | is_signed_i & (dvd_lo_i[15] ^ dvs_i[15]) & !is_wide_i;
      neg_r <= is_signed_i & (is_wide_i ? dvd_hi_i[15] : dvd_lo_i[15]);
      ovf <= (dvs_i == 16'h0000) || (mag_dvd[31:16] >= mag_dvs);
    end else begin
      shreg <= {shreg[30:0], ~trial[16]};
      rem <= trial[16] ? {rem[15:0], shreg[31]} : trial;
    end
  end

  // Sign fix-up of results
  always_comb begin
    quot_o = neg_q ? 16'(-shreg[15:0]) : shreg[15:0];
    rem_o = neg_r ? 16'(-rem[15:0]) : rem[15:0];
    ovf_o = ovf;
  end

endmodule

/* File: src/dce_core.sv */
`timescale 1ns/10ps
// Summary of operation
// - Signed 16/16 divide: 18 cycles, NZCV
// - Signed 32/16 divide: 18 cycles, NZCV
// - Unsigned 16/16 divide: 18 cycles, NZCV
// - Unsigned 32/16 divide: 18 cycles, NZCV
// - Fractional divide: 18 cycles, NZCV
// - Literal loop: count lit+1, two cycles
// - Register loop: count reg+1, two cycles
// - Distance square: one cycle, accumulator flags
// - Sign-change scan from MSB, carry only
// - Leading-one scan from MSB, carry only
// - Trailing-one scan from LSB, carry only
// - Single-bit right shift updates C,N,OV,Z
// - Multi-bit right shift updates N,Z only
// - 16-bit literal transfer, no flags
// - 8-bit literal transfer, no flags
// - Double transfer from pair, two cycles
// - Double transfer into pair, two cycles
// - Prefetch and store accumulator, one cycle
module dce_core
  import dce_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic issue_i,
  input wire dce_instr_t instr_i,
  output logic busy_o,
  output logic done_o,
  output dce_result_t result_o,
  output dce_flags_t flags_o,
  output logic loop_start_o,
  output logic [15:0] loop_count_o,
  output logic [15:0] loop_end_o,
  output logic prefetch_o,
  output logic [15:0] x_prefetch_o,
  output logic [15:0] y_prefetch_o,
  output logic acc_writeback_target_o,
  output logic [15:0] writeback_data_o
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic [4:0] lead_one(input logic [15:0] v);
    logic [4:0] pos;
    pos = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (pos == 5'h00 && v[15 - i]) begin
        pos = 5'(i + 1);
      end
    end
    return pos;
  endfunction

  function automatic logic [4:0] trail_one(input logic [15:0] v);
    logic [4:0] pos;
    pos = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (pos == 5'h00 && v[i]) begin
        pos = 5'(i + 1);
      end
    end
    return pos;
  endfunction

  function automatic logic is_div(input dce_op_t op);
    return op inside {DCE_OP_DIV_S, DCE_OP_SIGNED_WIDE_QUOTIENT_OP, DCE_OP_DIV_U, DCE_OP_UNSIGNED_WIDE_QUOTIENT_OP, DCE_OP_FRACTIONAL_QUOTIENT_OP};
  endfunction

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  typedef enum logic [1:0] {
    DCE_ST_IDLE = 2'b00,
    DCE_ST_DIV  = 2'b01,
    DCE_ST_TWO  = 2'b10
  } dce_state_t;

  dce_state_t state;
  dce_op_t cur_op;
  logic [4:0] cnt;
  dce_instr_t held;
  logic [15:0] div_quot;
  logic [15:0] div_rem;
  logic div_ovf;
  logic accept;

  assign accept = issue_i && state == DCE_ST_IDLE;

  // Divider engine
  dce_divider u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(accept && is_div(instr_i.op)),
    .is_signed_i(instr_i.op inside {DCE_OP_DIV_S, DCE_OP_SIGNED_WIDE_QUOTIENT_OP, DCE_OP_FRACTIONAL_QUOTIENT_OP}),
    .is_wide_i(instr_i.op inside {DCE_OP_SIGNED_WIDE_QUOTIENT_OP, DCE_OP_UNSIGNED_WIDE_QUOTIENT_OP}),
    .is_frac_i(instr_i.op == DCE_OP_FRACTIONAL_QUOTIENT_OP),
    .dvd_lo_i(instr_i.src_a),
    .dvd_hi_i(instr_i.src_b),
    .dvs_i(instr_i.op inside {DCE_OP_SIGNED_WIDE_QUOTIENT_OP, DCE_OP_UNSIGNED_WIDE_QUOTIENT_OP} ? instr_i.src_c : instr_i.src_b),
    .quot_o(div_quot),
    .rem_o(div_rem),
    .ovf_o(div_ovf)
  );

  // State and cycle count; issue stalls while busy
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= DCE_ST_IDLE;
      cnt <= 5'h00;
      cur_op <= DCE_OP_NONE;
      held <= '0;
    end else begin
      unique case (state)
        DCE_ST_IDLE: begin
          if (accept) begin
            cur_op <= instr_i.op;
            held <= instr_i;
            if (is_div(instr_i.op)) begin
              state <= DCE_ST_DIV;
              cnt <= DCE_DIV_CYCLES - 5'h01;
            end else if (instr_i.op inside {DCE_OP_LOOP_LIT, DCE_OP_LOOP_REG}) begin
              state <= DCE_ST_TWO;
              cnt <= DCE_LOOP_CYCLES - 5'h01;
            end else if (instr_i.op inside {DCE_OP_DBL_FROM, DCE_OP_DBL_TO}) begin
              state <= DCE_ST_TWO;
              cnt <= DCE_DBL_CYCLES - 5'h01;
            end
          end
        end
        DCE_ST_DIV, DCE_ST_TWO: begin
          cnt <= cnt - 5'h01;
          if (cnt == 5'h01) begin
            state <= DCE_ST_IDLE;
          end
        end
        default: begin
          state <= DCE_ST_IDLE;
        end
      endcase
    end
  end

  // Busy holds off issue until the final cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else if (accept) begin
      busy_o <= is_div(instr_i.op)
        || instr_i.op inside {DCE_OP_LOOP_LIT, DCE_OP_LOOP_REG, DCE_OP_DBL_FROM, DCE_OP_DBL_TO};
    end else if (state != DCE_ST_IDLE && cnt == 5'h01) begin
      busy_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Single-cycle datapath and completion
  // ----------------------------------------
  logic fin_multi;
  assign fin_multi = state != DCE_ST_IDLE && cnt == 5'h01;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      result_o <= '0;
      flags_o <= DCE_FLAGS_RST;
    end else begin
      done_o <= 1'b0;
      if (fin_multi) begin
        done_o <= 1'b1;
        if (is_div(cur_op)) begin
          result_o.lo <= div_quot;
          result_o.hi <= div_rem;
          flags_o.n <= div_quot[15];
          flags_o.z <= div_quot == DCE_WORD_RST;
          flags_o.c <= div_rem == DCE_WORD_RST;
          flags_o.ov <= div_ovf;
        end else if (cur_op == DCE_OP_DBL_FROM) begin
          result_o.lo <= held.src_a;
          result_o.hi <= held.src_b;
        end else if (cur_op == DCE_OP_DBL_TO) begin
          result_o.lo <= held.src_a;
          result_o.hi <= held.src_b;
        end
      end else if (accept) begin
        unique case (instr_i.op)
          DCE_OP_DIST_SQ: begin
            logic [31:0] d;
            logic [39:0] sq;
            logic signed [33:0] prod;
            logic ovf;
            logic clip;
            d = 32'(signed'(instr_i.src_a)) - 32'(signed'(instr_i.src_b));
            prod = $signed(d[16:0]) * $signed(d[16:0]); // Full 34-bit square
            sq = {6'h00, prod[33:0]};
            ovf = sq[39:31] != 9'h000;
            clip = sq[39:34] != 6'h00;
            done_o <= 1'b1;
            result_o.acc <= clip ? 40'h7F_FFFF_FFFF : sq;
            result_o.lo <= instr_i.src_c;
            result_o.hi <= instr_i.src_d;
            if (instr_i.awb_en) begin
              flags_o.acc_b_overflow_flag <= ovf;
              flags_o.acc_b_clipped_flag <= clip;
              flags_o.either_acc_overflow_flag <= ovf | flags_o.acc_a_overflow_flag;
              flags_o.any_acc_clipped_flag <= clip | flags_o.acc_a_clipped_flag;
            end else begin
              flags_o.acc_a_overflow_flag <= ovf;
              flags_o.acc_a_clipped_flag <= clip;
              flags_o.either_acc_overflow_flag <= ovf | flags_o.acc_b_overflow_flag;
              flags_o.any_acc_clipped_flag <= clip | flags_o.acc_b_clipped_flag;
            end
          end
          DCE_OP_SIGN_SCN: begin
            logic [4:0] p;
            p = lead_one(instr_i.src_a ^ {instr_i.src_a[14:0], instr_i.src_a[0]});
            done_o <= 1'b1;
            result_o.lo <= {11'h000, p};
            flags_o.c <= p == 5'h00;
          end
          DCE_OP_LEAD_SCN: begin
            logic [4:0] p;
            p = lead_one(instr_i.src_a);
            done_o <= 1'b1;
            result_o.lo <= {11'h000, p};
            flags_o.c <= p == 5'h00;
          end
          DCE_OP_TRAIL_SC: begin
            logic [4:0] p;
            p = trail_one(instr_i.src_a);
            done_o <= 1'b1;
            result_o.lo <= {11'h000, p};
            flags_o.c <= p == 5'h00;
          end
          DCE_OP_LSR1: begin
            done_o <= 1'b1;
            result_o.lo <= {1'b0, instr_i.src_a[15:1]};
            flags_o.c <= instr_i.src_a[0];
            flags_o.n <= 1'b0;
            flags_o.ov <= 1'b0;
            flags_o.z <= instr_i.src_a[15:1] == 15'h0000;
          end
          DCE_OP_LSRN: begin
            logic [15:0] r;
            r = instr_i.src_a >> instr_i.src_b[3:0];
            done_o <= 1'b1;
            result_o.lo <= r;
            flags_o.n <= r[15];
            flags_o.z <= r == DCE_WORD_RST;
          end
          DCE_OP_LIT16: begin
            done_o <= 1'b1;
            result_o.lo <= instr_i.src_a;
          end
          DCE_OP_LIT8: begin
            done_o <= 1'b1;
            result_o.lo <= {instr_i.src_b[15:8], instr_i.src_a[7:0]};
          end
          DCE_OP_PREFETCH: begin
            done_o <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Loop setup and prefetch outputs
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      loop_start_o <= 1'b0;
      loop_count_o <= DCE_WORD_RST;
      loop_end_o <= DCE_WORD_RST;
    end else begin
      loop_start_o <= 1'b0;
      if (fin_multi && cur_op inside {DCE_OP_LOOP_LIT, DCE_OP_LOOP_REG}) begin
        loop_start_o <= 1'b1;
        loop_end_o <= held.src_c;
        if (cur_op == DCE_OP_LOOP_LIT) begin
          loop_count_o <= {2'b00, held.src_a[DCE_LIT14_W-1:0]} + 16'h0001;
        end else begin
          loop_count_o <= held.src_a + 16'h0001;
        end
      end
    end
  end

  // Operand prefetch and accumulator write-back
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prefetch_o <= 1'b0;
      x_prefetch_o <= DCE_WORD_RST;
      y_prefetch_o <= DCE_WORD_RST;
      acc_writeback_target_o <= 1'b0;
      writeback_data_o <= DCE_WORD_RST;
    end else begin
      prefetch_o <= 1'b0;
      acc_writeback_target_o <= 1'b0;
      if (accept && instr_i.op inside {DCE_OP_PREFETCH, DCE_OP_DIST_SQ}) begin
        prefetch_o <= 1'b1;
        x_prefetch_o <= instr_i.src_c;
        y_prefetch_o <= instr_i.src_d;
        if (instr_i.op == DCE_OP_PREFETCH && instr_i.awb_en) begin
          acc_writeback_target_o <= 1'b1;
          writeback_data_o <= instr_i.src_a;
        end
      end
    end
  end

endmodule

/* File: dv/dce_core_sva.sv */
`timescale 1ns/10ps
module dce_core_sva
  import dce_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic issue_i,
  input wire dce_instr_t instr_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire dce_flags_t flags_o,
  input wire logic [15:0] loop_count_o
);
  // ----------------------------------------
  // Accepted instruction classes
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic take;
  dce_op_t op;
  // Offer counts only while the core is idle
  assign take = issue_i && !busy_o;
  assign op = instr_i.op;
  sequence div_taken;
    take && op inside {DCE_OP_DIV_S, DCE_OP_SIGNED_WIDE_QUOTIENT_OP, DCE_OP_DIV_U, DCE_OP_UNSIGNED_WIDE_QUOTIENT_OP, DCE_OP_FRACTIONAL_QUOTIENT_OP};
  endsequence
  sequence pair_taken;
    take && op inside {DCE_OP_LOOP_LIT, DCE_OP_LOOP_REG, DCE_OP_DBL_FROM, DCE_OP_DBL_TO};
  endsequence
  sequence one_taken;
    take && op inside {[DCE_OP_DIST_SQ:DCE_OP_LIT8], DCE_OP_PREFETCH};
  endsequence
  sequence pair_done;
    !done_o ##1 done_o;
  endsequence
  // ----------------------------------------
  // Latency, flag retention and loop count
  // ----------------------------------------
  a_div_latency: assert property (div_taken |-> ##18 done_o)
    else $error("divide done not 18 cycles after issue");
  a_div_stall: assert property (div_taken |=> (busy_o && !done_o)[*8])
    else $error("divide did not hold busy");
  a_single_done: assert property (one_taken |=> done_o)
    else $error("single cycle op missed done");
  a_pair_latency: assert property (pair_taken |=> pair_done)
    else $error("two cycle op done at wrong cycle");
  a_pair_keep: assert property (pair_taken |=> $stable(flags_o)[*2])
    else $error("two cycle op changed flags");
  a_scan_keep: assert property (take && op inside {[DCE_OP_SIGN_SCN:DCE_OP_TRAIL_SC]}
    |=> $stable({flags_o.n, flags_o.z, flags_o.ov})) else $error("scan changed n z ov");
  a_shift_keep: assert property (take && op == DCE_OP_LSRN
    |=> $stable({flags_o.c, flags_o.ov})) else $error("shift by amount changed c ov");
  a_move_keep: assert property (take && op inside {DCE_OP_LIT16, DCE_OP_LIT8, DCE_OP_PREFETCH}
    |=> $stable(flags_o)) else $error("move changed flags");
  a_dist_keep: assert property (take && op == DCE_OP_DIST_SQ |=> $stable(flags_o[9:6]))
    else $error("distance op changed n z c ov");
  a_loop_count: assert property (take && op == DCE_OP_LOOP_LIT
    |-> ##2 loop_count_o == {2'b00, $past(instr_i.src_a[13:0], 2)} + 16'h0001)
    else $error("loop count wrong");
endmodule

bind dce_core dce_core_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .issue_i(issue_i),
  .instr_i(instr_i), .busy_o(busy_o), .done_o(done_o), .flags_o(flags_o),
  .loop_count_o(loop_count_o));

/* File: dv/dce_core_tb_top.sv */
`timescale 1ns/10ps
module dce_core_tb_top
  import dce_pkg::*;
;
  typedef struct packed {
    logic [4:0] w;      // Check lo, hi, acc, loop, prefetch
    logic [15:0] lo;
    logic [3:0] f;
    logic [3:0] m;
    logic [15:0] hi;
    logic [15:0] a1;
    logic [15:0] a2;
    logic [39:0] acc;
  } dce_note_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic issue_i = 1'b0;
  dce_instr_t instr_i = '0;
  logic busy_o, done_o, loop_start_o, prefetch_o, awb_o;
  dce_result_t result_o;
  dce_flags_t flags_o;
  logic [15:0] lcount, lend, xpf, ypf, wbd, a, b;
  int mismatches = 0;
  int compares = 0;
  dce_note_t notes[$];
  logic [15:0] rnd = 16'h0019;

  // Free running clock
  always #2.5 clk_i = ~clk_i;

  dce_core dut (.clk_i(clk_i), .rst_i(rst_i), .issue_i(issue_i), .instr_i(instr_i),
    .busy_o(busy_o), .done_o(done_o), .result_o(result_o), .flags_o(flags_o),
    .loop_start_o(loop_start_o), .loop_count_o(lcount), .loop_end_o(lend),
    .prefetch_o(prefetch_o), .x_prefetch_o(xpf), .y_prefetch_o(ypf),
    .acc_writeback_target_o(awb_o), .writeback_data_o(wbd));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic dce_instr_t mk(dce_op_t op, logic [15:0] sa, sb = '0, sc = '0,
    sd = '0, logic w = 1'b0);
    return '{op, sa, sb, sc, sd, w};
  endfunction
  function automatic dce_note_t note(logic [4:0] w, logic [15:0] lo, logic [3:0] f = '0,
    m = '0, logic [15:0] hi = '0, a1 = '0, a2 = '0, logic [39:0] acc = '0);
    return '{w, lo, f, m, hi, a1, a2, acc};
  endfunction
  function automatic dce_note_t div_note(dce_op_t op, logic [15:0] sa, sb, sc = '0);
    logic signed [31:0] dd, dv, q, r;
    dd = (op == DCE_OP_DIV_S) ? {{16{sa[15]}}, sa} : (op == DCE_OP_DIV_U) ? {16'h0000, sa}
      : {sb, sa};
    dv = (op == DCE_OP_DIV_S) ? {{16{sb[15]}}, sb} : (op == DCE_OP_DIV_U) ? {16'h0000, sb}
      : (op == DCE_OP_SIGNED_WIDE_QUOTIENT_OP) ? {{16{sc[15]}}, sc} : {16'h0000, sc};
    if (dv == 0) return note(5'h00, '0, 4'h1, 4'h1);
    q = dd / dv;
    r = dd % dv;
    return note(5'h18, q[15:0], {q[15], q[15:0] == 16'h0000, r[15:0] == 16'h0000, 1'b0},
      4'hF, r[15:0]);
  endfunction
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_acc(input string nm, input logic [39:0] e, input logic [39:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (done_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk_word("done_wait", 16'h0000, (n >= 40) ? 16'h0001 : 16'h0000);
  endtask
  task automatic send(input dce_instr_t ins, input dce_note_t nt, input bit multi);
    issue_i = 1'b1;
    instr_i = ins;
    notes.push_back(nt);
    @(posedge clk_i);
    #1;
    if (multi) begin
      issue_i = 1'b0;
      wait_done();
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Result monitor, oldest note per completion
  always @(posedge clk_i) begin
    if (!rst_i && done_o === 1'b1) begin
      if (notes.size() == 0) begin
        chk_word("done_o", 16'h0000, 16'h0001);
      end else begin
        dce_note_t nt;
        nt = notes.pop_front();
        if (nt.w[4]) chk_word("result_lo", nt.lo, result_o.lo);
        if (nt.w[3]) chk_word("result_hi", nt.hi, result_o.hi);
        if (nt.w[2]) chk_acc("result_acc", nt.acc, result_o.acc);
        if (nt.w[1]) chk_word("loop_count", nt.a1, lcount);
        if (nt.w[1]) chk_word("loop_end", nt.a2, lend);
        if (nt.w[1]) chk_word("loop_start", 16'h0001, {15'h0000, loop_start_o});
        if (nt.w[0]) chk_word("x_prefetch", nt.a1, xpf);
        if (nt.w[0]) chk_word("y_prefetch", nt.a2, ypf);
        if (nt.w[0]) chk_word("prefetch", 16'h0001, {15'h0000, prefetch_o});
        if (nt.w[0]) chk_word("writeback_target", nt.lo, {15'h0000, awb_o});
        if (nt.w[0]) chk_word("writeback_data", nt.hi, wbd);
        if (nt.m != 4'h0) chk_word("flags", {12'h000, nt.f & nt.m},
          {12'h000, {flags_o.n, flags_o.z, flags_o.c, flags_o.ov} & nt.m});
      end
    end
  end

  // Watchdog
  initial begin
    #20000;
    mismatches++;
    $display("Error watchdog expected finish seen timeout");
    tally_and_finish();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      a = rnd;
      rnd = lfsr(rnd);
      b = {8'h00, rnd[7:0]} | 16'h0001;
      send(mk(DCE_OP_DIV_U, a, b), div_note(DCE_OP_DIV_U, a, b), 1);
    end
    send(mk(DCE_OP_DIV_U, 16'h0005), div_note(DCE_OP_DIV_U, 16'h0005, '0), 1);
    send(mk(DCE_OP_SIGNED_WIDE_QUOTIENT_OP, 16'h7960, 16'hFFFE, 16'h0007),
      div_note(DCE_OP_SIGNED_WIDE_QUOTIENT_OP, 16'h7960, 16'hFFFE, 16'h0007), 1);
    send(mk(DCE_OP_UNSIGNED_WIDE_QUOTIENT_OP, 16'h0000, 16'h0001, 16'h0002),
      div_note(DCE_OP_UNSIGNED_WIDE_QUOTIENT_OP, 16'h0000, 16'h0001, 16'h0002), 1);
    send(mk(DCE_OP_FRACTIONAL_QUOTIENT_OP, 16'h2000, 16'h4000), note(5'h18, 16'h4000, 4'h2, 4'hF), 1);
    // Offers made while the divide runs must be dropped
    send(mk(DCE_OP_DIV_S, 16'hFED4, 16'h0007), div_note(DCE_OP_DIV_S, 16'hFED4, 16'h0007), 0);
    instr_i = mk(DCE_OP_LIT16, rnd);
    repeat (3) begin
      @(posedge clk_i);
      #1;
    end
    issue_i = 1'b0;
    wait_done();
    send(mk(DCE_OP_LOOP_LIT, 16'h3FFF, '0, 16'h0010),
      note(5'h02, '0, '0, '0, '0, 16'h4000, 16'h0010), 1);
    send(mk(DCE_OP_LOOP_REG, 16'hFFFE, '0, 16'h0123),
      note(5'h02, '0, '0, '0, '0, 16'hFFFF, 16'h0123), 1);
    send(mk(DCE_OP_DIST_SQ, 16'h0005, 16'h0002, '0, '0, 1'b1),
      note(5'h04, '0, '0, '0, '0, '0, '0, 40'h00_0000_0009), 0);
    send(mk(DCE_OP_SIGN_SCN, 16'h00F0), note(5'h00, '0, 4'h0, 4'h2), 0);
    send(mk(DCE_OP_SIGN_SCN, 16'hFFFF), note(5'h10, 16'h0000, 4'h2, 4'h2), 0);
    send(mk(DCE_OP_LEAD_SCN, 16'h0100), note(5'h10, 16'h0008, 4'h0, 4'h2), 0);
    send(mk(DCE_OP_LEAD_SCN, 16'h0000), note(5'h10, 16'h0000, 4'h2, 4'h2), 0);
    send(mk(DCE_OP_TRAIL_SC, 16'h0100), note(5'h10, 16'h0009, 4'h0, 4'h2), 0);
    send(mk(DCE_OP_LSR1, 16'h8001), note(5'h10, 16'h4000, 4'h2, 4'hE), 0);
    send(mk(DCE_OP_LSR1, 16'h0001), note(5'h10, 16'h0000, 4'h6, 4'hE), 0);
    send(mk(DCE_OP_LSRN, 16'hF000, 16'h0004), note(5'h10, 16'h0F00, 4'h0, 4'hC), 0);
    send(mk(DCE_OP_LSRN, 16'h8000, 16'h000F), note(5'h10, 16'h0001, 4'h0, 4'hC), 0);
    send(mk(DCE_OP_LIT16, rnd), note(5'h10, rnd), 0);
    send(mk(DCE_OP_LIT8, 16'h00A5, 16'h3C00), note(5'h10, 16'h3CA5), 0);
    send(mk(DCE_OP_PREFETCH, 16'h9ABC, '0, 16'h1234, 16'h5678, 1'b1),
      note(5'h01, 16'h0001, '0, '0, 16'h9ABC, 16'h1234, 16'h5678), 0);
    send(mk(DCE_OP_PREFETCH, 16'h0F0F, '0, 16'h4321, 16'h8765),
      note(5'h01, 16'h0000, '0, '0, 16'h9ABC, 16'h4321, 16'h8765), 0);
    send(mk(DCE_OP_DBL_FROM, 16'hBEEF, 16'h0F0F), note(5'h18, 16'hBEEF, '0, '0, 16'h0F0F), 1);
    send(mk(DCE_OP_DBL_TO, 16'h1357, 16'h2468), note(5'h18, 16'h1357, '0, '0, 16'h2468), 1);
    repeat (4) @(posedge clk_i);
    chk_word("notes_left", 16'h0000, 16'(notes.size()));
    tally_and_finish();
  end
endmodule
